// ===== include/rtc_defines.svh
`ifndef RTC_DEFINES_SVH
`define RTC_DEFINES_SVH

// fixed upper nibble of every command byte
`define FIXED_CODE 4'h6

// status register one bit positions
`define ST1_POC 0
`define ST1_BLD 1
`define ST1_AL2 2
`define ST1_AL1 3
`define ST1_SCB 4
`define ST1_SCA 5
`define ST1_M24 6
`define ST1_INIT 7

// status register two bit positions
`define ST2_TEST 0
`define ST2_AL2EN 1
`define ST2_SCE 2
`define ST2_SCC 4
`define ST2_AL1EN 5
`define ST2_AL1M 6
`define ST2_AL1F 7

// reset values
`define RST_ST1 8'h01
`define RST_ST1_INIT 8'h00
`define RST_ST2 8'h80
`define RST_AL1 24'h80_0000
`define RST_AL2 24'h00_0000
`define RST_TRIM 8'h00
`define RST_USER 8'h00
`define RST_MONTH 4'h1
`define RST_DAY 5'h01

// transfer lengths in data bytes
`define BYTES_FULL 3'h7
`define BYTES_SHORT 3'h3
`define BYTES_ALARM 3'h3
`define BYTES_ONE 3'h1

// oscillator rising edges per second
`define OSC_TICKS_PER_SEC 32768

`endif

// ===== include/rtc_pkg.sv
package rtc_pkg;

    typedef enum logic [2:0] {
        CMD_ST1 = 3'h0,
        CMD_ST2 = 3'h1,
        CMD_FULL = 3'h2,
        CMD_SHORT = 3'h3,
        CMD_AL1 = 3'h4,
        CMD_AL2 = 3'h5,
        CMD_TRIM = 3'h6,
        CMD_USER = 3'h7
    } cmd_e;

    // binary time counters
    typedef struct packed {
        logic [6:0] year;
        logic [3:0] month;
        logic [4:0] day;
        logic [2:0] wday;
        logic [4:0] hour;
        logic [5:0] min;
        logic [5:0] sec;
    } time_s;

    // what one frame left behind in the link domain
    typedef struct packed {
        logic seq;
        logic ok;
        logic rd;
        cmd_e cmd;
        logic [2:0] nbytes;
        logic [55:0] data;
    } link_req_s;

    // readable image of every register, wire byte order
    typedef struct packed {
        logic [55:0] time_img;
        logic [7:0] st1;
        logic [7:0] st2;
        logic [23:0] al1;
        logic [23:0] al2;
        logic [7:0] trim;
        logic [7:0] user;
    } shadow_s;

endpackage

// ===== core/rtc_register_set.sv
// Contract
// - full time transfer: seven BCD bytes year to second, LSB weight at B7.
// - short time transfer: hour, minute, second only.
// - read command latches a coherent snapshot of all counters.
// - year is BCD 00 to 99, carries through 2099.
// - day wraps per month length; February 29 only in leap years.
// - weekday counts 00 to 06 then back to 00.
// - 12h mode takes written AM/PM; 24h mode reads PM for 12 to 23.
// - power-on flag at B0 set by power-on, cleared after read.
// - low-supply flag at B1 sticky, read-only.
// - alarm flags B3 and B2 set on match, cleared after read.
// - scratch bits are plain storage, two in status one, three in two.
// - status one B6 selects 12h (0) or 24h (1).
// - writing 1 to status one B7 initialises; reads back 0.
// - status two B1 enables alarm two.
// - alarm one is three bytes only when enable=1 and both mode bits 0.
// - alarm bytes hold weekday, hour, minute like the time counters.
// - B0 of each alarm byte enables that field in the match.
// - trim register is plain read/write byte, V0 at B7.
// - user byte is plain read/write storage, F0 at B7.
// - only code 0110 plus three select bits is a command.
// - power-on values: 01h, 80h, 80h, others 00h, date 00-01-01.
// - a written nonexistent date becomes first of the next month.
`include "rtc_defines.svh"

module rtc_register_set #(
    parameter int unsigned OSC_PER_SEC = `OSC_TICKS_PER_SEC
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic osc_32k,
    input wire logic low_supply_det,
    input wire logic cs,
    input wire logic sck,
    input wire logic sio_i,
    output logic sio_o,
    output logic sio_oe
);
    import rtc_pkg::*;

    function automatic logic [7:0] rev8(input logic [7:0] v);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            r[i] = v[7 - i];
        end
        return r;
    endfunction

    function automatic logic bcd_ok(input logic [7:0] b);
        return (b[3:0] <= 4'h9) && (b[7:4] <= 4'h9);
    endfunction

    function automatic logic [6:0] bcd2bin(input logic [7:0] b);
        return 7'(b[7:4] * 10 + b[3:0]);
    endfunction

    function automatic logic [7:0] bin2bcd(input logic [6:0] v);
        return {4'(v / 10), 4'(v % 10)};
    endfunction

    function automatic logic [4:0] days_in(input logic [3:0] m, input logic [6:0] y);
        unique case (m)
            4'h4, 4'h6, 4'h9, 4'hb: return 5'h1e;
            4'h2: return (y[1:0] == 2'h0) ? 5'h1d : 5'h1c;
            default: return 5'h1f;
        endcase
    endfunction

    // hour byte in host format to binary 24h; out of range gives 0
    function automatic logic [4:0] hour_in(input logic [7:0] v, input logic m24);
        logic [6:0] b;
        b = bcd2bin({2'h0, v[5:0]});
        if (!bcd_ok({2'h0, v[5:0]})) begin
            return 5'h00;
        end
        if (m24) begin
            return (b > 7'h17) ? 5'h00 : b[4:0];
        end
        if (b > 7'h0b) begin
            return 5'h00;
        end
        return v[6] ? 5'(b + 7'h0c) : b[4:0];
    endfunction

    function automatic logic [5:0] sixty_in(input logic [7:0] v);
        logic [7:0] m;
        m = {1'b0, v[6:0]};
        return (bcd_ok(m) && bcd2bin(m) <= 7'h3b) ? 6'(bcd2bin(m)) : 6'h00;
    endfunction

    function automatic time_s decode_time(input logic [55:0] img, input logic m24,
                                          input time_s cur, input logic full);
        time_s t;
        logic [7:0] mb;
        logic [7:0] db;
        logic [7:0] yb;
        t = cur;
        yb = rev8(img[55:48]);
        // unused high bits of month and day read as don't care
        mb = rev8(img[47:40]) & 8'h1f;
        db = rev8(img[39:32]) & 8'h3f;
        if (full) begin
            t.year = bcd_ok(yb) ? bcd2bin(yb) : 7'h00;
            t.month = (bcd_ok(mb) && mb != 8'h00 && mb <= 8'h12) ? 4'(bcd2bin(mb)) : 4'h1;
            t.day = (bcd_ok(db) && db != 8'h00 && db <= 8'h31) ? 5'(bcd2bin(db)) : 5'h01;
            t.wday = (rev8(img[31:24]) & 8'h07) == 8'h07 ? 3'h0 : 3'(rev8(img[31:24]));
            if (t.day > days_in(t.month, t.year)) begin
                t.day = 5'h01;
                if (t.month == 4'hc) begin
                    t.month = 4'h1;
                    t.year = (t.year == 7'h63) ? 7'h00 : t.year + 7'h01;
                end else begin
                    t.month = t.month + 4'h1;
                end
            end
            t.hour = hour_in(rev8(img[23:16]), m24);
            t.min = sixty_in(rev8(img[15:8]));
            t.sec = sixty_in(rev8(img[7:0]));
        end else begin
            t.hour = hour_in(rev8(img[55:48]), m24);
            t.min = sixty_in(rev8(img[47:40]));
            t.sec = sixty_in(rev8(img[39:32]));
        end
        return t;
    endfunction

    function automatic time_s next_time(input time_s t);
        time_s n;
        n = t;
        n.sec = t.sec + 6'h01;
        if (t.sec == 6'h3b) begin
            n.sec = 6'h00;
            n.min = t.min + 6'h01;
            if (t.min == 6'h3b) begin
                n.min = 6'h00;
                n.hour = (t.hour == 5'h17) ? 5'h00 : t.hour + 5'h01;
                if (t.hour == 5'h17) begin
                    n.wday = (t.wday == 3'h6) ? 3'h0 : t.wday + 3'h1;
                    n.day = t.day + 5'h01;
                    if (t.day >= days_in(t.month, t.year)) begin
                        n.day = 5'h01;
                        n.month = t.month + 4'h1;
                        if (t.month == 4'hc) begin
                            n.month = 4'h1;
                            n.year = (t.year == 7'h63) ? 7'h00 : t.year + 7'h01;
                        end
                    end
                end
            end
        end
        return n;
    endfunction

    // seven bytes, each bit-reversed so the lowest weight leaves first
    function automatic logic [55:0] time_image(input time_s t, input logic m24);
        logic pm;
        logic [4:0] h;
        logic [7:0] hb;
        pm = t.hour >= 5'h0c;
        h = (m24 || !pm) ? t.hour : 5'(t.hour - 5'h0c);
        hb = bin2bcd(7'(h));
        return {rev8(bin2bcd(t.year)), rev8(bin2bcd(7'(t.month))),
                rev8(bin2bcd(7'(t.day))), rev8({5'h00, t.wday}),
                rev8({1'b0, pm, hb[5:0]}), rev8(bin2bcd(7'(t.min))),
                rev8(bin2bcd(7'(t.sec)))};
    endfunction

    function automatic logic alarm_hit(input logic [23:0] al, input time_s t,
                                       input logic m24);
        logic [7:0] w;
        logic [7:0] h;
        logic [7:0] m;
        w = rev8(al[23:16]);
        h = rev8(al[15:8]);
        m = rev8(al[7:0]);
        return (w[7] || h[7] || m[7])
            && (!w[7] || w[2:0] == t.wday)
            && (!h[7] || hour_in(h, m24) == t.hour)
            && (!m[7] || sixty_in(m) == t.min);
    endfunction

    // ---------------- mclk domain: synchronisers ----------------
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic osc_prev_q;
    logic cs_prev_q;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
            osc_prev_q <= 1'b0;
            cs_prev_q <= 1'b0;
        end else begin
            sync1_q <= {cs, low_supply_det, osc_32k};
            sync2_q <= sync1_q;
            osc_prev_q <= sync2_q[0];
            cs_prev_q <= sync2_q[2];
        end
    end

    logic osc_rise;
    logic lowsup_s;
    logic cs_s;
    logic frame_end;
    assign osc_rise = sync2_q[0] && !osc_prev_q;
    assign lowsup_s = sync2_q[1];
    assign cs_s = sync2_q[2];
    assign frame_end = cs_prev_q && !cs_s;

    // ---------------- sck domain: serial link ----------------
    logic [2:0] bit_cnt_q;
    logic first_q;
    logic rd_act_q;
    logic [3:0] byte_idx_q;
    logic [6:0] in_q;
    logic [55:0] out_q;
    link_req_s lk_req_q;
    shadow_s shadow_q;

    logic byte_done;
    logic [7:0] in_byte;
    logic cmd_match;
    logic cmd_byte;
    assign byte_done = bit_cnt_q == 3'h7;
    assign in_byte = {in_q, sio_i};
    assign cmd_match = in_byte[7:4] == `FIXED_CODE;
    assign cmd_byte = byte_done && byte_idx_q == 4'h0;

    // frame state ends with the frame: chip select low clears it
    // reset too, so a chip select held high since power-up leaves no unknown state
    always_ff @(posedge sck or negedge cs or negedge rst_n) begin
        if (!cs || !rst_n) begin
            bit_cnt_q <= 3'h0;
            first_q <= 1'b1;
            rd_act_q <= 1'b0;
        end else begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            first_q <= 1'b0;
            if (cmd_byte && cmd_match && in_byte[0]) begin
                rd_act_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge sck or negedge rst_n) begin
        if (!rst_n) begin
            in_q <= 7'h00;
            byte_idx_q <= 4'h0;
        end else begin
            in_q <= in_byte[6:0];
            if (first_q) begin
                byte_idx_q <= 4'h0;
            end else if (byte_done && byte_idx_q != 4'h8) begin
                byte_idx_q <= byte_idx_q + 4'h1;
            end
        end
    end

    // request fields stay put after the frame until the next command byte
    always_ff @(posedge sck or negedge rst_n) begin
        if (!rst_n) begin
            lk_req_q <= '0;
        end else if (cmd_byte) begin
            lk_req_q.ok <= cmd_match;
            lk_req_q.seq <= lk_req_q.seq ^ cmd_match;
            lk_req_q.rd <= in_byte[0];
            lk_req_q.cmd <= cmd_e'(in_byte[3:1]);
            lk_req_q.nbytes <= 3'h0;
        end else if (byte_done && byte_idx_q != 4'h0 && byte_idx_q != 4'h8 && !lk_req_q.rd) begin
            lk_req_q.data[(8 - int'(byte_idx_q)) * 8 - 1 -: 8] <= in_byte;
            lk_req_q.nbytes <= byte_idx_q[2:0];
        end
    end

    // shadow_q is frozen while cs is high, so reading it here is stable
    always_ff @(posedge sck or negedge rst_n) begin
        if (!rst_n) begin
            out_q <= 56'h00_0000_0000_0000;
        end else if (cmd_byte && cmd_match && in_byte[0]) begin
            unique case (cmd_e'(in_byte[3:1]))
                CMD_ST1: out_q <= {shadow_q.st1, 48'h0000_0000_0000};
                CMD_ST2: out_q <= {shadow_q.st2, 48'h0000_0000_0000};
                CMD_FULL: out_q <= shadow_q.time_img;
                CMD_SHORT: out_q <= {shadow_q.time_img[23:0], 32'h0000_0000};
                CMD_AL1: out_q <= {shadow_q.al1, 32'h0000_0000};
                CMD_AL2: out_q <= {shadow_q.al2, 32'h0000_0000};
                CMD_TRIM: out_q <= {shadow_q.trim, 48'h0000_0000_0000};
                CMD_USER: out_q <= {shadow_q.user, 48'h0000_0000_0000};
            endcase
        end else begin
            out_q <= {out_q[54:0], 1'b0};
        end
    end

    assign sio_o = out_q[55];
    assign sio_oe = rd_act_q;

    // ---------------- mclk domain: registers ----------------
    time_s tm_q;
    logic poc_q;
    logic bld_q;
    logic al1_flag_q;
    logic al2_flag_q;
    logic [2:0] st1_cfg_q;
    logic [7:0] st2_q;
    logic [23:0] al1_q;
    logic [23:0] al2_q;
    logic [7:0] trim_bits;
    logic [7:0] user_bits;
    logic seen_seq_q;
    logic [15:0] presc_q;
    logic al1_prev_q;
    logic al2_prev_q;

    logic mode24;
    logic frame_new;
    logic rd_st1;
    logic [2:0] need;
    logic wr_ok;
    logic [7:0] b0;
    logic init;
    logic wr_time;
    logic sec_tick;
    logic al1_active;
    logic al1_match;
    logic al2_match;

    assign mode24 = st1_cfg_q[2];
    assign al1_active = st2_q[`ST2_AL1EN] && !st2_q[`ST2_AL1M] && !st2_q[`ST2_AL1F];
    assign frame_new = frame_end && lk_req_q.ok && lk_req_q.seq != seen_seq_q;
    assign rd_st1 = frame_new && lk_req_q.rd && lk_req_q.cmd == CMD_ST1;
    assign b0 = lk_req_q.data[55:48];

    always_comb begin
        unique case (lk_req_q.cmd)
            CMD_FULL: need = `BYTES_FULL;
            CMD_SHORT: need = `BYTES_SHORT;
            CMD_AL1: need = al1_active ? `BYTES_ALARM : `BYTES_ONE;
            CMD_AL2: need = `BYTES_ALARM;
            default: need = `BYTES_ONE;
        endcase
    end

    // short writes are dropped whole rather than half-applied
    assign wr_ok = frame_new && !lk_req_q.rd && lk_req_q.nbytes >= need;
    assign init = wr_ok && lk_req_q.cmd == CMD_ST1 && b0[`ST1_INIT];
    assign wr_time = wr_ok && (lk_req_q.cmd == CMD_FULL || lk_req_q.cmd == CMD_SHORT);
    assign sec_tick = osc_rise && presc_q == 16'(OSC_PER_SEC - 1);
    assign al1_match = al1_active && alarm_hit(al1_q, tm_q, mode24);
    assign al2_match = st2_q[`ST2_AL2EN] && alarm_hit(al2_q, tm_q, mode24);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            seen_seq_q <= 1'b0;
        end else if (frame_end) begin
            seen_seq_q <= lk_req_q.seq;
        end
    end

    // a time write restarts the second so the new value lasts a full second
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            presc_q <= 16'h0000;
        end else if (init || wr_time || sec_tick) begin
            presc_q <= 16'h0000;
        end else if (osc_rise) begin
            presc_q <= presc_q + 16'h0001;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tm_q <= '{month: `RST_MONTH, day: `RST_DAY, default: '0};
        end else if (init) begin
            tm_q <= '{month: `RST_MONTH, day: `RST_DAY, default: '0};
        end else if (wr_time) begin
            tm_q <= decode_time(lk_req_q.data, mode24, tm_q, lk_req_q.cmd == CMD_FULL);
        end else if (sec_tick) begin
            tm_q <= next_time(tm_q);
        end
    end

    // flags: a set in the same cycle as a read-clear wins
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            poc_q <= 1'(`RST_ST1 >> `ST1_POC);
            bld_q <= 1'b0;
            al1_flag_q <= 1'b0;
            al2_flag_q <= 1'b0;
            al1_prev_q <= 1'b0;
            al2_prev_q <= 1'b0;
        end else if (init) begin
            poc_q <= 1'(`RST_ST1_INIT >> `ST1_POC);
            bld_q <= 1'b0;
            al1_flag_q <= 1'b0;
            al2_flag_q <= 1'b0;
            al1_prev_q <= 1'b0;
            al2_prev_q <= 1'b0;
        end else begin
            al1_prev_q <= al1_match;
            al2_prev_q <= al2_match;
            poc_q <= poc_q && !(rd_st1 && shadow_q.st1[`ST1_POC]);
            bld_q <= lowsup_s || (bld_q && !(rd_st1 && shadow_q.st1[`ST1_BLD]));
            al1_flag_q <= (al1_match && !al1_prev_q)
                || (al1_flag_q && !(rd_st1 && shadow_q.st1[`ST1_AL1]));
            al2_flag_q <= (al2_match && !al2_prev_q)
                || (al2_flag_q && !(rd_st1 && shadow_q.st1[`ST1_AL2]));
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st1_cfg_q <= 3'h0;
            st2_q <= `RST_ST2;
            al1_q <= `RST_AL1;
            al2_q <= `RST_AL2;
            trim_bits <= `RST_TRIM;
            user_bits <= `RST_USER;
        end else if (init) begin
            st1_cfg_q <= 3'h0;
            st2_q <= `RST_ST2;
            al1_q <= `RST_AL1;
            al2_q <= `RST_AL2;
            trim_bits <= `RST_TRIM;
            user_bits <= `RST_USER;
        end else if (wr_ok) begin
            unique case (lk_req_q.cmd)
                CMD_ST1: st1_cfg_q <= b0[`ST1_M24:`ST1_SCB];
                CMD_ST2: st2_q <= b0;
                CMD_AL1: begin
                    if (al1_active) begin
                        al1_q <= lk_req_q.data[55:32];
                    end else begin
                        al1_q[23:16] <= b0;
                    end
                end
                CMD_AL2: al2_q <= lk_req_q.data[55:32];
                CMD_TRIM: trim_bits <= b0;
                CMD_USER: user_bits <= b0;
                default: ;
            endcase
        end
    end

    // snapshot refreshed only outside frames
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            shadow_q <= '0;
        end else if (!cs_s) begin
            shadow_q.time_img <= time_image(tm_q, mode24);
            shadow_q.st1 <= {1'b0, st1_cfg_q, al1_flag_q, al2_flag_q, bld_q, poc_q};
            shadow_q.st2 <= st2_q;
            shadow_q.al1 <= al1_active ? al1_q : {al1_q[23:16], 16'h0000};
            shadow_q.al2 <= al2_q;
            shadow_q.trim <= trim_bits;
            shadow_q.user <= user_bits;
        end
    end

    // ---------------- checks ----------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence s_tick_quiet;
        sec_tick && !init && !wr_time;
    endsequence

    sequence s_day_end;
        s_tick_quiet ##0 tm_q.sec == 6'h3b && tm_q.min == 6'h3b && tm_q.hour == 5'h17;
    endsequence

    a_sec_advance: assert property (s_tick_quiet ##0 tm_q.sec != 6'h3b
        |=> tm_q.sec == $past(tm_q.sec) + 6'h01 && $stable(tm_q.min))
        else $error("seconds did not advance by one");
    a_weekday_wrap: assert property (s_day_end ##0 tm_q.wday == 3'h6 |=> tm_q.wday == 3'h0)
        else $error("weekday did not wrap to zero");
    a_feb_length: assert property (s_day_end ##0 tm_q.month == 4'h2
        && tm_q.day == (tm_q.year[1:0] == 2'h0 ? 5'h1d : 5'h1c)
        |=> tm_q.day == 5'h01 && tm_q.month == 4'h3)
        else $error("february end not handled");
    a_year_wrap: assert property (s_day_end ##0 tm_q.month == 4'hc && tm_q.day == 5'h1f
        && tm_q.year == 7'h63 |=> tm_q.year == 7'h00 && tm_q.month == 4'h1)
        else $error("year did not wrap after 99");
    a_poc_clear: assert property (rd_st1 && shadow_q.st1[`ST1_POC] && !init |=> !poc_q)
        else $error("power-on flag not cleared by read");
    a_bld_sticky: assert property (bld_q && !init && !rd_st1 |=> bld_q)
        else $error("low-supply flag dropped without read");
    a_al1_gate: assert property (!al1_active |=> !$rose(al1_flag_q))
        else $error("alarm one flag set while not in alarm mode");
    a_init_values: assert property (init |=> st2_q == `RST_ST2 && al1_q == `RST_AL1
        && !poc_q && tm_q.month == `RST_MONTH && shadow_q.st1[`ST1_INIT] == 1'b0)
        else $error("init did not restore register values");
    a_scratch_store: assert property (wr_ok && lk_req_q.cmd == CMD_ST1 && !init
        |=> st1_cfg_q == $past(b0[`ST1_M24:`ST1_SCB]))
        else $error("status one scratch bits not stored");
    a_cmd_gate: assert property (@(posedge sck) disable iff (!rst_n || !cs)
        cmd_byte && !cmd_match |=> !rd_act_q)
        else $error("unrecognised code started a read");

endmodule // rtc_register_set

// ===== sim/rtc_host_model.sv
module rtc_host_model (
    output logic cs,
    output logic sck,
    output logic sio_i,
    input wire logic sio_o
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        cs = 1'b0;
        sck = 1'b0;
        sio_i = 1'b0;
    end

    // n data bytes in wire order, the last byte in the low bits
    task automatic xfer(input logic [7:0] cmd, input int n, input logic [55:0] wd,
                        output logic [55:0] rd);
        logic [63:0] sh;
        sh = {cmd, 56'(wd << (56 - 8 * n))};
        rd = '0;
        #7 cs = 1'b1;
        for (int i = 0; i < 8 + 8 * n; i++) begin
            // a released line toggles so a stale bit cannot pass for data
            sio_i = (i < 8 || !cmd[0]) ? sh[63] : ~sio_i;
            sh = sh << 1;
            #15 sck = 1'b1;
            if (i >= 8) begin
                rd = {rd[54:0], sio_o};
            end
            #15 sck = 1'b0;
        end
        #7 cs = 1'b0;
        sio_i = ~sio_i;
        #40;
    endtask
endmodule // rtc_host_model

// ===== sim/test_rtc_register_set.sv
module test_rtc_register_set;
    timeunit 1ns;
    timeprecision 100ps;
    import rtc_pkg::*;
    logic mclk, rst_n, osc, ls, oe_seen;
    wire logic cs, sck, sio_i, sio_o, sio_oe;
    int n_mismatch, samples_checked;
    logic [31:0] seed;
    logic [55:0] rd;
    logic [7:0] ub;

    rtc_register_set #(.OSC_PER_SEC(4)) dut_u (.mclk(mclk), .rst_n(rst_n), .osc_32k(osc),
        .low_supply_det(ls), .cs(cs), .sck(sck), .sio_i(sio_i), .sio_o(sio_o), .sio_oe(sio_oe));
    // released line reads high, as with a pull-up
    rtc_host_model host_u (.cs(cs), .sck(sck), .sio_i(sio_i), .sio_o(sio_oe ? sio_o : 1'b1));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    always @(posedge sck) if (sio_oe) oe_seen = 1'b1;

    function automatic logic [7:0] rv(input logic [7:0] v);
        for (int i = 0; i < 8; i++) rv[i] = v[7 - i];
    endfunction
    // bcd bytes to wire image, am/pm bit read back in 24h mode
    function automatic logic [55:0] tim(input logic [55:0] b);
        for (int i = 0; i < 7; i++) tim[8 * i +: 8] = rv(b[8 * i +: 8]);
        tim[17] = b[23:16] >= 8'h12;
    endfunction
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    task automatic chk(input string what, input logic [55:0] got, input logic [55:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic acc(input cmd_e c, input logic r, input int n, input logic [55:0] w);
        host_u.xfer({4'h6, c, r}, n, w, rd);
    endtask
    task automatic rc(input cmd_e c, input int n, input logic [55:0] e, input string s);
        acc(c, 1'b1, n, 56'h0);
        chk(s, rd, e);
    endtask
    task automatic tick(input int n);
        repeat (n) begin
            repeat (25) @(posedge mclk);
            osc <= 1'b1;
            repeat (25) @(posedge mclk);
            osc <= 1'b0;
        end
        repeat (8) @(posedge mclk);
    endtask
    task automatic cal(input logic [55:0] w, input int k, input logic [55:0] e);
        acc(CMD_FULL, 1'b0, 7, tim(w));
        tick(k);
        rc(CMD_FULL, 7, tim(e), "time");
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        #400us;
        n_mismatch++;
        wrap_up();
    end

    initial begin
        rst_n = 1'b0;
        osc = 1'b0;
        ls = 1'b0;
        oe_seen = 1'b0;
        seed = 32'h5bbb_74bd;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        rc(CMD_ST1, 1, 56'h01, "st1");
        rc(CMD_ST1, 1, 56'h00, "st1 reread");
        rc(CMD_ST2, 1, 56'h80, "st2");
        rc(CMD_AL1, 1, 56'h80, "al1 free");
        rc(CMD_AL2, 3, 56'h0, "al2");
        rc(CMD_TRIM, 1, 56'h0, "trim");
        rc(CMD_FULL, 7, tim(56'h00_0101_0000_0000), "time");
        $display("test reset done");
        acc(CMD_ST1, 1'b0, 1, 56'hF0);
        rc(CMD_ST1, 1, 56'h00, "init");
        acc(CMD_SHORT, 1'b0, 3, tim(56'h11_4530) | 56'h02_0000);
        rc(CMD_SHORT, 3, tim(56'h11_4530) | 56'h02_0000, "12h pm");
        acc(CMD_ST1, 1'b0, 1, 56'h70);
        rc(CMD_ST1, 1, 56'h70, "mode");
        rc(CMD_SHORT, 3, tim(56'h23_4530), "24h pm");
        repeat (8) begin
            seed = xs(seed);
            ub = seed[7:0];
            acc(CMD_USER, 1'b0, 1, 56'(ub));
            acc(CMD_TRIM, 1'b0, 1, 56'(seed[15:8]));
            acc(CMD_ST2, 1'b0, 1, 56'(8'h80 | (seed[23:16] & 8'h1C)));
            rc(CMD_USER, 1, 56'(ub), "user");
            rc(CMD_TRIM, 1, 56'(seed[15:8]), "trim");
            rc(CMD_ST2, 1, 56'(8'h80 | (seed[23:16] & 8'h1C)), "st2");
        end
        $display("test storage done");
        oe_seen = 1'b0;
        host_u.xfer(8'h5F, 1, 56'h0, rd);
        chk("bad code oe", 56'(oe_seen), 56'h0);
        host_u.xfer(8'h7E, 1, 56'(~ub), rd);
        rc(CMD_USER, 1, 56'(ub), "bad code write");
        $display("test command code done");
        cal(56'h99_1231_0623_5959, 5, 56'h00_0101_0000_0000);
        cal(56'h24_0228_0323_5959, 5, 56'h24_0229_0400_0000);
        cal(56'h23_0228_0323_5959, 5, 56'h23_0301_0400_0000);
        cal(56'h23_0430_0123_5959, 5, 56'h23_0501_0200_0000);
        cal(56'h23_0230_0112_0000, 0, 56'h23_0301_0112_0000);
        acc(CMD_SHORT, 1'b0, 3, tim(56'h10_2030));
        rc(CMD_SHORT, 3, tim(56'h10_2030), "short");
        rc(CMD_FULL, 7, tim(56'h23_0301_0110_2030), "after short");
        $display("test calendar done");
        for (int a = 0; a < 2; a++) begin
            acc(CMD_ST2, 1'b0, 1, a ? 56'h02 : 56'h20);
            acc(a ? CMD_AL2 : CMD_AL1, 1'b0, 3, tim(56'h00_1000) | 56'h0101);
            rc(a ? CMD_AL2 : CMD_AL1, 3, tim(56'h00_1000) | 56'h0101, "alarm");
            acc(CMD_SHORT, 1'b0, 3, tim(56'h09_5959));
            tick(5);
            rc(CMD_ST1, 1, a ? 56'h74 : 56'h78, "alarm flag");
            rc(CMD_ST1, 1, 56'h70, "alarm flag reread");
            acc(CMD_ST2, 1'b0, 1, 56'h0);
        end
        ls <= 1'b1;
        repeat (6) @(posedge mclk);
        ls <= 1'b0;
        repeat (6) @(posedge mclk);
        rc(CMD_ST1, 1, 56'h72, "low supply");
        rc(CMD_ST1, 1, 56'h70, "low supply reread");
        $display("test flags done");
        wrap_up();
    end
endmodule // test_rtc_register_set
